// ---- cctl_pkg.sv ----
// constants shared by the cache control and way lock block
package cctl_pkg;
  // register byte offsets, decoded on the low address bits
  localparam int         DEC_W      = 8;
  localparam logic [7:0] OFS_CTL    = 8'h00;
  localparam logic [7:0] OFS_WLK    = 8'h04;
  // cache_control fields
  localparam int          CTL_CE     = 0;
  localparam int          CTL_WT     = 1;
  localparam int          CTL_CB     = 2;
  localparam int          CTL_CF     = 3;
  localparam logic [31:0] CTL_MASK   = 32'h0000_0007;
  localparam logic [31:0] CTL_RST    = 32'h0000_0000;
  // way_lock_control fields
  localparam int          WLK_LK2    = 0;
  localparam int          WLK_LD2    = 1;
  localparam int          WLK_LK3    = 8;
  localparam int          WLK_LD3    = 9;
  localparam logic [31:0] WLK_MASK   = 32'h0000_0303;
  localparam logic [31:0] WLK_RST    = 32'h0000_0000;
  // cache lock mode bit of the processor status word
  localparam int          PSW_CL     = 12;
  // recency field: each bit orders one pair of ways, 1 = lower way is older
  localparam int          REC_W      = 6;
  localparam int          R01        = 5;
  localparam int          R02        = 4;
  localparam int          R03        = 3;
  localparam int          R12        = 2;
  localparam int          R13        = 1;
  localparam int          R23        = 0;
  localparam logic [5:0]  REC_RST    = 6'h00;
  // geometry
  localparam int          WAYS       = 4;
  localparam int          SETS       = 256;
  localparam int          SET_W      = 8;
  localparam logic [1:0]  WAY0       = 2'h0;
  localparam logic [1:0]  WAY1       = 2'h1;
  localparam logic [1:0]  WAY2       = 2'h2;
  localparam logic [1:0]  WAY3       = 2'h3;
  // access segment codes
  localparam logic [1:0]  SEG_USER   = 2'h0;
  localparam logic [1:0]  SEG_KERN   = 2'h1;
  localparam logic [1:0]  SEG_NC     = 2'h2;
  // bus constants
  localparam logic [1:0]  HRESP_OKAY = 2'h0;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
endpackage

// ---- cctl_victim.sv ----
// victim way selection from recency field and lock settings
`timescale 1ns/10ps
`default_nettype none
module cctl_victim
  import cctl_pkg::*;
(
  // recency state and mode
  input  wire logic [REC_W-1:0] rec_i,
  input  wire logic             lock_mode_i,
  input  wire logic             line_preload_instr_i,
  // way lock settings
  input  wire logic             lk2_i,
  input  wire logic             ld2_i,
  input  wire logic             lk3_i,
  input  wire logic             ld3_i,
  // selected way
  output logic      [1:0]       way_o,
  output logic                  forced_o
);
  logic [1:0] w_norm;
  logic [1:0] w_lk2;
  logic [1:0] w_lk3;
  logic [1:0] w_both;
  logic       f2;
  logic       f3;

  always_comb begin
    w_norm = WAY3;
    if (rec_i[R01] && rec_i[R02] && rec_i[R03]) begin
      w_norm = WAY0;
    end else if (!rec_i[R01] && rec_i[R12] && rec_i[R13]) begin
      w_norm = WAY1;
    end else if (!rec_i[R02] && !rec_i[R12] && rec_i[R23]) begin
      w_norm = WAY2;
    end
    // way 2 out of reach
    w_lk2 = rec_i[R01] && rec_i[R03] ? WAY0 : (!rec_i[R01] && rec_i[R13] ? WAY1 : WAY3);
    // way 3 out of reach
    w_lk3 = rec_i[R01] && rec_i[R02] ? WAY0 : (!rec_i[R01] && rec_i[R12] ? WAY1 : WAY2);
    w_both = rec_i[R01] ? WAY0 : WAY1;
    f2 = lock_mode_i && line_preload_instr_i && lk2_i && ld2_i && !ld3_i;
    f3 = lock_mode_i && line_preload_instr_i && lk3_i && ld3_i && !ld2_i;
    forced_o = f2 || f3;
    if (f2) begin
      way_o = WAY2;
    end else if (f3) begin
      way_o = WAY3;
    end else if (!lock_mode_i) begin
      way_o = w_norm;
    end else begin
      // load bits ignored here, only locks restrict the mapping
      case ({lk3_i, lk2_i})
        2'h1:    way_o = w_lk2;
        2'h2:    way_o = w_lk3;
        2'h3:    way_o = w_both;
        default: way_o = w_norm;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- cctl_recency.sv ----
// recency field update marking one way most recently used
`timescale 1ns/10ps
`default_nettype none
module cctl_recency
  import cctl_pkg::*;
(
  // current field and accessed way
  input  wire logic [REC_W-1:0] rec_i,
  input  wire logic [1:0]       way_i,
  // updated field
  output logic      [REC_W-1:0] rec_o
);
  always_comb begin
    rec_o = rec_i;
    // only the three pair bits of the accessed way change, so the result stays legal
    case (way_i)
      WAY0: begin
        rec_o[R01] = 1'b0;
        rec_o[R02] = 1'b0;
        rec_o[R03] = 1'b0;
      end
      WAY1: begin
        rec_o[R01] = 1'b1;
        rec_o[R12] = 1'b0;
        rec_o[R13] = 1'b0;
      end
      WAY2: begin
        rec_o[R02] = 1'b1;
        rec_o[R12] = 1'b1;
        rec_o[R23] = 1'b0;
      end
      default: begin
        rec_o[R03] = 1'b1;
        rec_o[R13] = 1'b1;
        rec_o[R23] = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- cctl_top.sv ----
// cache control registers, per-set state and victim selection with way locking
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - lookup and allocation only while the cache enable bit is set.
// - flush write clears valid, dirty and recency everywhere, no write-back; reads 0.
// - kernel unmapped segment policy bit: 1 write-back, 0 write-through.
// - user and mapped segment policy bit: 1 write-through, 0 write-back.
// - reserved control bits read 0 and never store written values.
// - lock settings act only while status word bit 12 is set.
// - prefetch miss goes to way 2 when lock2, load2 set, load3 clear.
// - prefetch miss goes to way 3 when lock3, load3 set, load2 clear.
// - prefetch hit fetches nothing and keeps the existing entry.
// - in lock mode ordinary misses pick victims from lock bits and recency; load bits are ignored.
// - unforced prefetch misses in lock mode use the lock-restricted mapping.
// - only way 2 locked: victim is way 3, 1 or 0.
// - only way 3 locked: victim is way 2, 1 or 0.
// - both locked: victim is way 1 or way 0.
// - locked ways are never replaced except by a forced prefetch load.
// - way lock register is write-only; its reads carry no stored value.
// - without lock mode or locks the normal recency mapping applies.
// - power-on reset clears recency; manual reset leaves it alone.
module cctl_top
  import cctl_pkg::*;
#(
  parameter int N_SETS = SETS,
  parameter int N_SW   = SET_W
) (
  // clock and resets
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  input  wire logic             MRST_I,
  // ahb-lite slave
  input  wire logic             HSEL_I,
  input  wire logic [31:0]      HADDR_I,
  input  wire logic [1:0]       HTRANS_I,
  input  wire logic             HWRITE_I,
  input  wire logic [2:0]       HSIZE_I,
  input  wire logic [31:0]      HWDATA_I,
  input  wire logic             HREADY_I,
  output logic                  HREADYOUT_O,
  output logic      [31:0]      HRDATA_O,
  output logic      [1:0]       HRESP_O,
  // core access request
  input  wire logic [31:0]      PSW_I,
  input  wire logic             ACC_VALID_I,
  input  wire logic [N_SW-1:0]  ACC_SET_I,
  input  wire logic             ACC_WRITE_I,
  input  wire logic             ACC_LINE_PRELOAD_INSTR_I,
  input  wire logic [1:0]       ACC_SEG_I,
  input  wire logic [WAYS-1:0]  TAG_MATCH_I,
  // access result
  output logic                  RES_VALID_O,
  output logic                  RES_BYPASS_O,
  output logic                  RES_HIT_O,
  output logic                  RES_FILL_O,
  output logic      [1:0]       RES_WAY_O,
  output logic                  RES_WBACK_O,
  output logic                  RES_EVICT_DIRTY_O,
  // status
  output logic                  CACHE_EN_O,
  output logic                  FLUSH_O
);
  typedef struct packed {
    logic [N_SETS-1:0][REC_W-1:0] rec;
    logic [N_SETS-1:0][WAYS-1:0]  valid;
    logic [N_SETS-1:0][WAYS-1:0]  dirty;
    logic [31:0]                  ctl;
    logic [31:0]                  wlk;
    logic                         dp_wr;
    logic [DEC_W-1:0]             dp_addr;
    logic                         hready;
    logic [31:0]                  hrdata;
    logic [1:0]                   hresp;
    logic                         res_valid;
    logic                         res_bypass;
    logic                         res_hit;
    logic                         res_fill;
    logic [1:0]                   res_way;
    logic                         res_wback;
    logic                         res_evict;
    logic                         flush;
  } cctl_state_s;

  cctl_state_s      st;
  cctl_state_s      next_st;
  logic             lock_mode;
  logic [REC_W-1:0] cur_rec;
  logic [WAYS-1:0]  hit_vec;
  logic             hit;
  logic [1:0]       hit_way;
  logic [1:0]       vict_way;
  logic             vict_forced;
  logic [1:0]       upd_way;
  logic [REC_W-1:0] upd_rec;
  logic             take;
  logic             flush_wr;
  logic             wback;
  logic             cached;

  assign lock_mode = PSW_I[PSW_CL];
  assign cur_rec   = st.rec[ACC_SET_I];
  assign hit_vec   = TAG_MATCH_I & st.valid[ACC_SET_I];
  assign hit       = |hit_vec;
  assign upd_way   = hit ? hit_way : vict_way;

  always_comb begin
    hit_way = WAY0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_way = 2'(i);
      end
    end
  end

  cctl_victim u_victim (
    .rec_i       (cur_rec),
    .lock_mode_i (lock_mode),
    .line_preload_instr_i      (ACC_LINE_PRELOAD_INSTR_I),
    .lk2_i       (st.wlk[WLK_LK2]),
    .ld2_i       (st.wlk[WLK_LD2]),
    .lk3_i       (st.wlk[WLK_LK3]),
    .ld3_i       (st.wlk[WLK_LD3]),
    .way_o       (vict_way),
    .forced_o    (vict_forced)
  );

  cctl_recency u_recency (
    .rec_i (cur_rec),
    .way_i (upd_way),
    .rec_o (upd_rec)
  );

  always_comb begin
    next_st = st;
    next_st.hready     = 1'b1;
    next_st.hresp      = HRESP_OKAY;
    next_st.res_valid  = 1'b0;
    next_st.res_bypass = 1'b0;
    next_st.res_hit    = 1'b0;
    next_st.res_fill   = 1'b0;
    next_st.res_evict  = 1'b0;
    next_st.flush      = 1'b0;
    // policy for this access by segment
    wback  = (ACC_SEG_I == SEG_KERN) ? st.ctl[CTL_CB] : !st.ctl[CTL_WT];
    cached = st.ctl[CTL_CE] && (ACC_SEG_I == SEG_USER || ACC_SEG_I == SEG_KERN);
    // address phase capture
    take = HSEL_I && HREADY_I && HTRANS_I[1];
    next_st.dp_wr   = take && HWRITE_I;
    next_st.dp_addr = HADDR_I[DEC_W-1:0];
    // data phase write commit
    flush_wr = 1'b0;
    if (st.dp_wr) begin
      case (st.dp_addr)
        OFS_CTL: begin
          next_st.ctl = HWDATA_I & CTL_MASK;
          flush_wr    = HWDATA_I[CTL_CF];
        end
        OFS_WLK: begin
          next_st.wlk = HWDATA_I & WLK_MASK;
        end
        default: begin
        end
      endcase
    end
    // core access, ignored while the core is in manual reset
    if (ACC_VALID_I && !MRST_I) begin
      next_st.res_valid  = 1'b1;
      next_st.res_wback  = wback;
      next_st.res_way    = upd_way;
      if (!cached) begin
        next_st.res_bypass = 1'b1;
      end else if (hit) begin
        next_st.res_hit = 1'b1;
        // prefetch hit only refreshes recency
        next_st.rec[ACC_SET_I] = upd_rec;
        if (ACC_WRITE_I && !ACC_LINE_PRELOAD_INSTR_I && wback) begin
          next_st.dirty[ACC_SET_I][hit_way] = 1'b1;
        end
      end else if (!(ACC_WRITE_I && !ACC_LINE_PRELOAD_INSTR_I && !wback)) begin
        // allocate; a write-through write miss goes to memory only
        next_st.res_fill  = 1'b1;
        next_st.res_evict = st.valid[ACC_SET_I][vict_way] && st.dirty[ACC_SET_I][vict_way];
        next_st.rec[ACC_SET_I]             = upd_rec;
        next_st.valid[ACC_SET_I][vict_way] = 1'b1;
        next_st.dirty[ACC_SET_I][vict_way] = ACC_WRITE_I && !ACC_LINE_PRELOAD_INSTR_I;
      end
    end
    // flush wins over a same-cycle access, nothing is written back
    if (flush_wr) begin
      next_st.rec   = '0;
      next_st.valid = '0;
      next_st.dirty = '0;
      next_st.flush = 1'b1;
    end
    // manual reset returns the control registers, arrays are kept
    if (MRST_I) begin
      next_st.ctl = CTL_RST;
      next_st.wlk = WLK_RST;
    end
    // read data from the post-write value; way lock reads zero
    next_st.hrdata = RD_ZERO;
    if (take && !HWRITE_I && HADDR_I[DEC_W-1:0] == OFS_CTL) begin
      next_st.hrdata = next_st.ctl & CTL_MASK;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st        <= '0;
      st.hready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign HREADYOUT_O       = st.hready;
  assign HRDATA_O          = st.hrdata;
  assign HRESP_O           = st.hresp;
  assign RES_VALID_O       = st.res_valid;
  assign RES_BYPASS_O      = st.res_bypass;
  assign RES_HIT_O         = st.res_hit;
  assign RES_FILL_O        = st.res_fill;
  assign RES_WAY_O         = st.res_way;
  assign RES_WBACK_O       = st.res_wback;
  assign RES_EVICT_DIRTY_O = st.res_evict;
  assign CACHE_EN_O        = st.ctl[CTL_CE];
  assign FLUSH_O           = st.flush;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_acc;
    ACC_VALID_I && !MRST_I;
  endsequence

  sequence s_flush_wr;
    st.dp_wr && st.dp_addr == OFS_CTL && HWDATA_I[CTL_CF];
  endsequence

  sequence s_line_preload_instr_miss;
    s_acc ##0 cached && ACC_LINE_PRELOAD_INSTR_I && !hit && lock_mode;
  endsequence

  a_bypass_when_off: assert property (
    s_acc ##0 !st.ctl[CTL_CE] |=> RES_BYPASS_O && !RES_FILL_O && !RES_HIT_O)
    else $error("access used the cache while disabled");

  a_flush_clears_all: assert property (
    s_flush_wr |=> st.rec == '0 && st.valid == '0 && st.dirty == '0 && FLUSH_O)
    else $error("flush left state behind");

  a_ctl_reserved_zero: assert property (
    (st.ctl & ~CTL_MASK) == RD_ZERO && !st.ctl[CTL_CF])
    else $error("reserved or flush bit stored");

  a_kernel_policy: assert property (
    s_acc ##0 ACC_SEG_I == SEG_KERN |=> RES_WBACK_O == $past(st.ctl[CTL_CB]))
    else $error("kernel segment policy wrong");

  a_user_policy: assert property (
    s_acc ##0 ACC_SEG_I == SEG_USER |=> RES_WBACK_O != $past(st.ctl[CTL_WT]))
    else $error("user segment policy wrong");

  a_force_way_two: assert property (
    s_line_preload_instr_miss ##0 st.wlk[WLK_LK2] && st.wlk[WLK_LD2] && !st.wlk[WLK_LD3]
    |=> RES_FILL_O && RES_WAY_O == WAY2)
    else $error("forced prefetch not in way 2");

  a_force_way_three: assert property (
    s_line_preload_instr_miss ##0 st.wlk[WLK_LK3] && st.wlk[WLK_LD3] && !st.wlk[WLK_LD2]
    |=> RES_FILL_O && RES_WAY_O == WAY3)
    else $error("forced prefetch not in way 3");

  a_line_preload_instr_hit_keep: assert property (
    s_acc ##0 cached && ACC_LINE_PRELOAD_INSTR_I && hit && !flush_wr
    |=> RES_HIT_O && !RES_FILL_O && st.valid == $past(st.valid))
    else $error("prefetch hit changed entries");

  a_lock2_spared: assert property (
    lock_mode && st.wlk[WLK_LK2] && !vict_forced |-> vict_way != WAY2)
    else $error("locked way 2 chosen");

  a_lock3_spared: assert property (
    lock_mode && st.wlk[WLK_LK3] && !vict_forced |-> vict_way != WAY3)
    else $error("locked way 3 chosen");

  a_wlk_read_zero: assert property (
    take && !HWRITE_I && HADDR_I[DEC_W-1:0] == OFS_WLK |=> HRDATA_O == RD_ZERO)
    else $error("way lock read leaked state");

  a_mrst_keeps_rec: assert property (
    MRST_I && !flush_wr |=> st.rec == $past(st.rec) && st.ctl == CTL_RST)
    else $error("manual reset touched recency");

  a_hit_most_recent: assert property (
    s_acc ##0 cached && hit && !flush_wr ##1 !lock_mode
    |-> vict_way != $past(hit_way) || ACC_SET_I != $past(ACC_SET_I))
    else $error("hit way not marked most recent");

  a_normal_reset_way: assert property (
    !lock_mode && cur_rec == REC_RST |-> vict_way == WAY3)
    else $error("normal mapping of cleared recency wrong");

  a_lock2_reset_way: assert property (
    lock_mode && st.wlk[WLK_LK2] && !st.wlk[WLK_LK3] && !vict_forced && cur_rec == REC_RST
    |-> vict_way == WAY3)
    else $error("way 2 lock mapping wrong");

  a_lock3_reset_way: assert property (
    lock_mode && st.wlk[WLK_LK3] && !st.wlk[WLK_LK2] && !vict_forced && cur_rec == REC_RST
    |-> vict_way == WAY2)
    else $error("way 3 lock mapping wrong");

  a_both_reset_way: assert property (
    lock_mode && st.wlk[WLK_LK2] && st.wlk[WLK_LK3] && !vict_forced && cur_rec == REC_RST
    |-> vict_way == WAY1)
    else $error("two-way lock mapping wrong");

  a_ordinary_spares_two: assert property (
    s_acc ##0 cached && lock_mode && !ACC_LINE_PRELOAD_INSTR_I && !hit && st.wlk[WLK_LK2]
    |=> RES_WAY_O != WAY2)
    else $error("ordinary miss chose locked way 2");

  a_no_force_unlocked: assert property (
    !lock_mode |-> !vict_forced)
    else $error("forced load outside lock mode");

  a_bypass_keeps_state: assert property (
    s_acc ##0 !cached && !flush_wr
    |=> st.valid == $past(st.valid) && st.dirty == $past(st.dirty) && st.rec == $past(st.rec))
    else $error("bypassed access changed cache state");

  a_wthru_no_alloc: assert property (
    s_acc ##0 cached && !hit && ACC_WRITE_I && !ACC_LINE_PRELOAD_INSTR_I && !wback
    |=> !RES_FILL_O && !RES_HIT_O)
    else $error("write-through write miss allocated");

  a_flush_reads_zero: assert property (
    take && !HWRITE_I && HADDR_I[DEC_W-1:0] == OFS_CTL |=> !HRDATA_O[CTL_CF])
    else $error("flush bit read back as one");

  a_result_follows_access: assert property (
    s_acc |=> RES_VALID_O)
    else $error("accepted access gave no result");

  a_no_spurious_result: assert property (
    !(ACC_VALID_I && !MRST_I) |=> !RES_VALID_O)
    else $error("result without an accepted access");

  a_bus_zero_wait: assert property (
    HREADYOUT_O && HRESP_O == HRESP_OKAY)
    else $error("bus answer not ready and okay");
endmodule
`default_nettype wire

// ---- cctl_core_model.sv ----
// processor core model issuing accesses to the cache control block
`timescale 1ns/10ps
`default_nettype none
module cctl_core_model (
  // clock
  input  wire logic       clk_i,
  // access request
  output logic     [31:0] psw_o,
  output logic            valid_o,
  output logic     [7:0]  set_o,
  output logic            write_o,
  output logic            line_preload_instr_o,
  output logic     [1:0]  seg_o,
  output logic     [3:0]  match_o,
  // access result, valid bit on top
  input  wire logic [7:0] res_i
);
  logic [7:0] res;
  initial begin
    psw_o = 32'h0000_0000;
    valid_o = 1'b0;
    {set_o, write_o, line_preload_instr_o, seg_o, match_o} = 16'h0000;
    res = 8'h00;
  end
  // one access after gap idle cycles; released fields show the inverse
  task automatic issue(input logic [7:0] s, input logic [3:0] op,
                       input logic [3:0] m, input logic cl, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    valid_o <= 1'b1;
    set_o <= s;
    {write_o, line_preload_instr_o, seg_o} <= op;
    match_o <= m;
    psw_o <= {19'h0, cl, 12'h000};
    @(posedge clk_i);
    valid_o <= 1'b0;
    set_o <= ~s;
    {write_o, line_preload_instr_o, seg_o} <= ~op;
    match_o <= ~m;
    #1 res = res_i;
  endtask
endmodule
`default_nettype wire

// ---- test_cache_control_and_way_lock.sv ----
// self-checking bench for cache control and way locking
`timescale 1ns/10ps
`default_nettype none
module test_cache_control_and_way_lock;
  import cctl_pkg::*;
  logic        clk, rst, mrst, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire  [31:0] hrdata, psw;
  wire  [7:0]  aset, res;
  wire  [3:0]  am;
  wire  [1:0]  hresp, aseg;
  wire         hready, av, aw, ap, cen, fl;
  int          errors, num_checks;

  cctl_top dut (
    .CLK_I(clk), .RST_I(rst), .MRST_I(mrst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp),
    .PSW_I(psw), .ACC_VALID_I(av), .ACC_SET_I(aset), .ACC_WRITE_I(aw),
    .ACC_LINE_PRELOAD_INSTR_I(ap), .ACC_SEG_I(aseg), .TAG_MATCH_I(am), .RES_VALID_O(res[7]),
    .RES_BYPASS_O(res[6]), .RES_HIT_O(res[5]), .RES_FILL_O(res[4]),
    .RES_WAY_O(res[3:2]), .RES_WBACK_O(res[1]), .RES_EVICT_DIRTY_O(res[0]),
    .CACHE_EN_O(cen), .FLUSH_O(fl));

  cctl_core_model core (
    .clk_i(clk), .psw_o(psw), .valid_o(av), .set_o(aset), .write_o(aw),
    .line_preload_instr_o(ap), .seg_o(aseg), .match_o(am), .res_i(res));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) miss(m);
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) miss(m);
  endtask

  // expected {bypass, hit, fill, way} of the last access
  task automatic chk_res(input logic [4:0] e, input string m);
    num_checks++;
    if (core.res[7:2] !== {1'b1, e}) miss(m);
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 16) begin
        miss("bus wait timed out");
        tally_and_finish;
      end
      @(posedge clk);
    end
  endtask

  // the core model stays idle while a register transfer runs
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    hsel <= 1'b0;
    hwrite <= ~w;
    haddr <= ~{24'h000000, a};
    hwdata <= ~wd;
  endtask

  task automatic test_regs;
    ahb(1'b0, OFS_CTL, 32'h0);
    chk_reg(rd, CTL_RST, "ctl reset value");
    ahb(1'b1, OFS_CTL, 32'hFFFF_FFF7);
    ahb(1'b0, OFS_CTL, 32'h0);
    chk_reg(rd, 32'h0000_0007, "reserved ctl bits");
    chk_bit(cen, 1'b1, "enable level");
    ahb(1'b1, OFS_WLK, 32'h0000_0101);
    ahb(1'b0, OFS_WLK, 32'h0);
    chk_reg(rd, RD_ZERO, "lock reg read");
    ahb(1'b0, 8'h08, 32'h0);
    chk_reg(rd, RD_ZERO, "unmapped read");
    chk_reg({30'h0, hresp}, {30'h0, HRESP_OKAY}, "bus response");
    $display("test regs done");
  endtask

  task automatic test_normal;
    logic [1:0] hw [3] = '{WAY3, WAY1, WAY0};
    ahb(1'b1, OFS_CTL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      core.issue(8'h00, 4'h0, 4'h0, 1'b0, i);
      chk_res({3'b001, 2'(3 - i)}, "normal victim");
    end
    core.issue(8'h00, 4'h8, 4'h4, 1'b0, 0);
    chk_res({3'b010, WAY2}, "write hit");
    for (int i = 0; i < 3; i++) begin
      core.issue(8'h00, 4'h0, 4'h1 << hw[i], 1'b0, 0);
      chk_res({3'b010, hw[i]}, "read hit");
    end
    core.issue(8'h00, 4'h0, 4'h0, 1'b0, 0);
    chk_res({3'b001, WAY2}, "oldest way");
    chk_bit(core.res[0], 1'b1, "dirty victim");
    $display("test normal done");
  endtask

  task automatic test_mrst;
    core.issue(8'h00, 4'h0, 4'h8, 1'b0, 0);
    chk_res({3'b010, WAY3}, "hit before reset");
    @(posedge clk);
    mrst <= 1'b1;
    @(posedge clk);
    mrst <= 1'b0;
    ahb(1'b0, OFS_CTL, 32'h0);
    chk_reg(rd, CTL_RST, "ctl after manual reset");
    ahb(1'b1, OFS_CTL, 32'h0000_0003);
    core.issue(8'h00, 4'h8, 4'h0, 1'b0, 0);
    chk_res({3'b000, WAY1}, "recency kept");
    core.issue(8'h00, 4'h0, 4'h1, 1'b0, 0);
    chk_res({3'b010, WAY0}, "valid kept");
    $display("test manual reset done");
  endtask

  task automatic test_policy;
    logic [31:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 32'h1 | (i << 1);
      ahb(1'b1, OFS_CTL, c);
      core.issue(8'h00, {2'b00, SEG_USER}, 4'h1, 1'b0, 0);
      chk_bit(core.res[1], ~c[CTL_WT], "user policy");
      core.issue(8'h00, {2'b00, SEG_KERN}, 4'h1, 1'b0, 0);
      chk_bit(core.res[1], c[CTL_CB], "kernel policy");
    end
    core.issue(8'h00, {2'b00, SEG_NC}, 4'h1, 1'b0, 0);
    chk_bit(core.res[6], 1'b1, "uncached bypass");
    ahb(1'b1, OFS_CTL, 32'h0);
    core.issue(8'h00, 4'h0, 4'h1, 1'b0, 0);
    chk_bit(core.res[6] & ~core.res[5], 1'b1, "disabled bypass");
    $display("test policy done");
  endtask

  task automatic test_flush;
    ahb(1'b1, OFS_CTL, 32'h0000_0001);
    core.issue(8'h00, 4'h8, 4'h8, 1'b0, 0);
    chk_res({3'b010, WAY3}, "dirty write");
    ahb(1'b1, OFS_CTL, 32'h0000_0009);
    #1 chk_bit(fl, 1'b1, "flush pulse");
    ahb(1'b0, OFS_CTL, 32'h0);
    chk_reg(rd, 32'h0000_0001, "flush reads zero");
    core.issue(8'h00, 4'h0, 4'hF, 1'b0, 0);
    chk_res({3'b001, WAY3}, "flushed miss");
    chk_bit(core.res[0], 1'b0, "no write-back");
    $display("test flush done");
  endtask

  task automatic test_lock;
    logic [31:0] wl [5] = '{32'h101, 32'h001, 32'h003, 32'h100, 32'h101};
    logic [1:0]  ex [5] = '{WAY2, WAY1, WAY1, WAY2, WAY1};
    ahb(1'b1, OFS_CTL, 32'h0000_0003);
    core.issue(8'h02, 4'h0, 4'h0, 1'b0, 0);
    chk_res({3'b001, WAY3}, "first fill");
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, OFS_WLK, wl[i]);
      core.issue(8'h02, 4'h8, 4'h0, i != 0, 0);
      chk_res({3'b000, ex[i]}, "lock victim");
    end
    ahb(1'b1, OFS_WLK, 32'h201);
    core.issue(8'h02, 4'h4, 4'h0, 1'b1, 0);
    chk_res({3'b001, WAY1}, "unforced preload");
    ahb(1'b1, OFS_WLK, 32'h003);
    core.issue(8'h02, 4'h4, 4'h0, 1'b1, 0);
    chk_res({3'b001, WAY2}, "preload way two");
    ahb(1'b1, OFS_WLK, 32'h300);
    core.issue(8'h02, 4'h4, 4'h0, 1'b1, 0);
    chk_res({3'b001, WAY3}, "preload way three");
    core.issue(8'h02, 4'h4, 4'h2, 1'b1, 0);
    chk_res({3'b010, WAY1}, "preload hit");
    $display("test lock done");
  endtask

  initial begin
    rst = 1'b1;
    mrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_regs;
    test_normal;
    test_mrst;
    test_policy;
    test_flush;
    test_lock;
    tally_and_finish;
  end
endmodule
`default_nettype wire
